// >>> design/gtr_pkg.sv
// Package with the constants of the gate timing readback bank
package gtr_pkg;
	// Widths of the register read port and of one measurement field, and the register count
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned CNT_W = 6;
	localparam int unsigned NUM_REGS = 5;

	// Register offsets on the serial register interface
	localparam logic [6:0] HB3_EFFECTIVE_ON_OFF_DELAY_OFS = 7'h55;
	localparam logic [6:0] HB4_EFFECTIVE_ON_OFF_DELAY_OFS = 7'h56;
	localparam logic [6:0] HB1_RISE_FALL_TIME_OFS = 7'h57;
	localparam logic [6:0] HB2_RISE_FALL_TIME_OFS = 7'h58;
	localparam logic [6:0] HB3_RISE_FALL_TIME_OFS = 7'h59;

	// Slot numbers of the registers, in offset order
	localparam int unsigned SLOT_HB3_DELAY = 0;
	localparam int unsigned SLOT_HB4_DELAY = 1;
	localparam int unsigned SLOT_HB1_RISEFALL = 2;
	localparam int unsigned SLOT_HB2_RISEFALL = 3;
	localparam int unsigned SLOT_HB3_RISEFALL = 4;

	// Field positions inside one register
	localparam int unsigned LO_FIELD_LSB = 0;
	localparam int unsigned LO_FIELD_MSB = 5;
	localparam int unsigned HI_FIELD_LSB = 8;
	localparam int unsigned HI_FIELD_MSB = 13;

	// Value after power-on or soft reset, and of every reserved range
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [1:0] RESERVED_VAL = 2'h0;
	localparam logic [5:0] CNT_RESET = 6'h00;

	// Nominal time represented by one count, in picoseconds (53.3 ns)
	localparam int unsigned COUNT_STEP_PS = 53300;

	typedef logic [ADDR_W-1:0] gtr_addr_t;
	typedef logic [DATA_W-1:0] gtr_word_t;
	typedef logic [CNT_W-1:0] gtr_cnt_t;
endpackage

// >>> design/gtr_slot_if.sv
// Interface between the bank top and one timing register slot
interface gtr_slot_if;
	logic lo_valid; // New low-field count present
	logic hi_valid; // New high-field count present
	gtr_pkg::gtr_cnt_t lo_cnt; // Turn-on delay or rise time count
	gtr_pkg::gtr_cnt_t hi_cnt; // Turn-off delay or fall time count
	logic restart; // Restart event, fields kept
	gtr_pkg::gtr_word_t word; // Register image as read

	// Bank top feeds measurements and reads the image
	modport feeder (output lo_valid, output hi_valid, output lo_cnt, output hi_cnt,
		output restart, input word);
	// Slot stores the fields and drives the image
	modport store (input lo_valid, input hi_valid, input lo_cnt, input hi_cnt,
		input restart, output word);
endinterface

// >>> design/gtr_slot.sv
// One read-only timing register holding two 6-bit counts
module gtr_slot (
	input wire logic i_mclk,
	input wire logic i_rst,
	gtr_slot_if.store slot
);
	gtr_pkg::gtr_cnt_t lo_q; // Low field, bits 5:0
	gtr_pkg::gtr_cnt_t hi_q; // High field, bits 13:8

	// Low field takes the latest measurement; reset clears, restart keeps
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			lo_q <= gtr_pkg::CNT_RESET;
		end else if (slot.lo_valid) begin
			lo_q <= slot.lo_cnt;
		end
	end

	// High field takes the latest measurement; reset clears, restart keeps
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			hi_q <= gtr_pkg::CNT_RESET;
		end else if (slot.hi_valid) begin
			hi_q <= slot.hi_cnt;
		end
	end

	// Reserved ranges are tied to zero in the image
	assign slot.word = {gtr_pkg::RESERVED_VAL, hi_q, gtr_pkg::RESERVED_VAL, lo_q};

	// Reset leaves an all-zero register
	property p_slot_reset_clear;
		@(posedge i_mclk) i_rst |=> slot.word == gtr_pkg::REG_RESET;
	endproperty
	a_slot_reset_clear: assert property (p_slot_reset_clear) else $error("slot not cleared");

	// Restart without new data keeps both fields
	property p_slot_restart_keep;
		@(posedge i_mclk) disable iff (i_rst)
		(slot.restart && !slot.lo_valid && !slot.hi_valid) |=> $stable(slot.word);
	endproperty
	a_slot_restart_keep: assert property (p_slot_restart_keep) else $error("restart lost");

	// A new count is visible one cycle later and holds without further update
	property p_slot_update;
		@(posedge i_mclk) disable iff (i_rst)
		(slot.lo_valid && !slot.hi_valid) ##1 (!slot.lo_valid && !slot.hi_valid)[*2]
		|-> slot.word[5:0] == $past(slot.lo_cnt, 2);
	endproperty
	a_slot_update: assert property (p_slot_update) else $error("count not stored");
endmodule

// >>> design/gtr_bank.sv
// Gate timing readback bank: five read-only timing registers
// Contract
// - Reserved bits read zero, writes ignored
// - Delay registers: turn-off count at 13:8
// - Delay registers: turn-on count at 5:0
// - Rise-fall registers: rise count at 5:0
// - Rise-fall registers: fall count at 13:8
// - Reset clears every register to zero
// - Restart keeps fields, reserved stay zero
module gtr_bank #(
	parameter int unsigned NUM_REGS = gtr_pkg::NUM_REGS
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_restart,
	input wire logic i_rd_en,
	input wire gtr_pkg::gtr_addr_t i_rd_addr,
	input wire logic i_wr_en,
	input wire gtr_pkg::gtr_addr_t i_wr_addr,
	input wire logic [NUM_REGS-1:0] i_lo_valid,
	input wire logic [NUM_REGS-1:0][5:0] i_lo_cnt,
	input wire logic [NUM_REGS-1:0] i_hi_valid,
	input wire logic [NUM_REGS-1:0][5:0] i_hi_cnt,
	output logic [15:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_wr_refused
);
	// Register images, one per slot
	gtr_pkg::gtr_word_t words [NUM_REGS];
	// Read decode
	logic rd_hit;
	gtr_pkg::gtr_addr_t rd_index;
	gtr_pkg::gtr_word_t rd_word;
	// Write decode, used only to report the refused access
	logic wr_hit;
	// Output flops
	gtr_pkg::gtr_word_t rd_data_q;
	logic rd_valid_q;
	logic wr_refused_q;

	// One storage slot per register, fed from the measurement ports
	for (genvar g = 0; g < NUM_REGS; g++) begin : g_slot
		gtr_slot_if slot_bus ();
		assign slot_bus.lo_valid = i_lo_valid[g];
		assign slot_bus.lo_cnt = i_lo_cnt[g];
		assign slot_bus.hi_valid = i_hi_valid[g];
		assign slot_bus.hi_cnt = i_hi_cnt[g];
		assign slot_bus.restart = i_restart;
		assign words[g] = slot_bus.word;
		gtr_slot u_slot (
			.i_mclk(i_mclk),
			.i_rst(i_rst),
			.slot(slot_bus)
		);
	end

	// Offsets 0x55 to 0x59 form a contiguous window
	always_comb begin
		rd_hit = (i_rd_addr >= gtr_pkg::HB3_EFFECTIVE_ON_OFF_DELAY_OFS) &&
			(i_rd_addr <= gtr_pkg::HB3_RISE_FALL_TIME_OFS);
		rd_index = i_rd_addr - gtr_pkg::HB3_EFFECTIVE_ON_OFF_DELAY_OFS;
		// Unmapped addresses read as zero
		rd_word = gtr_pkg::REG_RESET;
		if (rd_hit) begin
			rd_word = words[rd_index[2:0]];
		end
	end

	// Writes to the bank are decoded only to flag them
	always_comb begin
		wr_hit = (i_wr_addr >= gtr_pkg::HB3_EFFECTIVE_ON_OFF_DELAY_OFS) &&
			(i_wr_addr <= gtr_pkg::HB3_RISE_FALL_TIME_OFS);
	end

	// Read data: captured on the request edge, held until the next read
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rd_data_q <= gtr_pkg::REG_RESET;
		end else if (i_rd_en) begin
			rd_data_q <= rd_word;
		end
	end

	// Read strobe: one cycle after each request
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= i_rd_en;
		end
	end

	// A write to a read-only register changes nothing; it is only reported
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			wr_refused_q <= 1'b0;
		end else begin
			wr_refused_q <= i_wr_en && wr_hit;
		end
	end

	assign o_rd_data = rd_data_q;
	assign o_rd_valid = rd_valid_q;
	assign o_wr_refused = wr_refused_q;

	// Reserved ranges never read as one
	property p_rd_reserved_zero;
		@(posedge i_mclk) disable iff (i_rst)
		o_rd_valid |-> (o_rd_data[15:14] == 2'h0) && (o_rd_data[7:6] == 2'h0);
	endproperty
	a_rd_reserved_zero: assert property (p_rd_reserved_zero) else $error("reserved bit set");

	// Writes never disturb the stored fields of slots 0 and 4
	property p_wr_no_effect;
		@(posedge i_mclk) disable iff (i_rst)
		(i_wr_en && i_lo_valid == '0 && i_hi_valid == '0) |=>
			words[0] == $past(words[0]) && words[4] == $past(words[4]);
	endproperty
	a_wr_no_effect: assert property (p_wr_no_effect) else $error("write changed register");

	// Turn-off delay of half-bridge 4 reads at 13:8
	property p_rd_turnoff;
		@(posedge i_mclk) disable iff (i_rst)
		(i_rd_en && i_rd_addr == gtr_pkg::HB4_EFFECTIVE_ON_OFF_DELAY_OFS) |=>
			o_rd_valid && o_rd_data[13:8] == $past(words[1][13:8]);
	endproperty
	a_rd_turnoff: assert property (p_rd_turnoff) else $error("turn-off field wrong");

	// Turn-on delay of half-bridge 3 reads at 5:0, two cycles after measurement
	property p_rd_turnon;
		@(posedge i_mclk) disable iff (i_rst)
		(i_lo_valid[0] ##1 (i_rd_en && !i_lo_valid[0] &&
			i_rd_addr == gtr_pkg::HB3_EFFECTIVE_ON_OFF_DELAY_OFS)) |=>
			o_rd_data[5:0] == $past(i_lo_cnt[0], 2);
	endproperty
	a_rd_turnon: assert property (p_rd_turnon) else $error("turn-on field wrong");

	// Rise time of half-bridge 1 reads at 5:0
	property p_rd_rise;
		@(posedge i_mclk) disable iff (i_rst)
		(i_rd_en && i_rd_addr == gtr_pkg::HB1_RISE_FALL_TIME_OFS) |=>
			o_rd_data[5:0] == $past(words[2][5:0]);
	endproperty
	a_rd_rise: assert property (p_rd_rise) else $error("rise field wrong");

	// Fall time of half-bridge 2 reads at 13:8 and holds until the next read
	property p_rd_fall;
		@(posedge i_mclk) disable iff (i_rst)
		(i_rd_en && i_rd_addr == gtr_pkg::HB2_RISE_FALL_TIME_OFS) ##1 !i_rd_en |=>
			o_rd_data[13:8] == $past(words[3][13:8], 2);
	endproperty
	a_rd_fall: assert property (p_rd_fall) else $error("fall field wrong");

	// Reset empties the read port
	property p_rst_clear;
		@(posedge i_mclk) i_rst |=> o_rd_data == gtr_pkg::REG_RESET && !o_rd_valid;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("read port not cleared");

	// A read in the same cycle as a restart returns the fields held before it
	property p_restart_read;
		@(posedge i_mclk) disable iff (i_rst)
		(i_restart && i_lo_valid == '0 && i_hi_valid == '0 && i_rd_en &&
			i_rd_addr == gtr_pkg::HB3_RISE_FALL_TIME_OFS) |=>
			o_rd_data == $past(words[4]);
	endproperty
	a_restart_read: assert property (p_restart_read) else $error("restart read wrong");

	// Read after an update sees the new fall count
	property p_update_read;
		@(posedge i_mclk) disable iff (i_rst)
		(i_hi_valid[4] ##1 (i_rd_en && !i_hi_valid[4] &&
			i_rd_addr == gtr_pkg::HB3_RISE_FALL_TIME_OFS)) |=>
			o_rd_data[13:8] == $past(i_hi_cnt[4], 2);
	endproperty
	a_update_read: assert property (p_update_read) else $error("stale measurement");

	// Every read request answers with a valid pulse one cycle later
	property p_rd_valid_pulse;
		@(posedge i_mclk) disable iff (i_rst)
		i_rd_en |=> o_rd_valid;
	endproperty
	a_rd_valid_pulse: assert property (p_rd_valid_pulse) else $error("no read valid");

	// No valid pulse without a request
	property p_rd_idle_quiet;
		@(posedge i_mclk) disable iff (i_rst)
		!i_rd_en |=> !o_rd_valid;
	endproperty
	a_rd_idle_quiet: assert property (p_rd_idle_quiet) else $error("spurious read valid");

	// A write into the bank is reported as refused one cycle later
	property p_wr_refused_pulse;
		@(posedge i_mclk) disable iff (i_rst)
		(i_wr_en && wr_hit) |=> o_wr_refused;
	endproperty
	a_wr_refused_pulse: assert property (p_wr_refused_pulse) else $error("write not flagged");

	// Turn-off delay of half-bridge 3 reads at 13:8
	property p_rd_hb3_turnoff;
		@(posedge i_mclk) disable iff (i_rst)
		(i_rd_en && i_rd_addr == gtr_pkg::HB3_EFFECTIVE_ON_OFF_DELAY_OFS) |=>
			o_rd_data[13:8] == $past(words[0][13:8]);
	endproperty
	a_rd_hb3_turnoff: assert property (p_rd_hb3_turnoff) else $error("hb3 turn-off wrong");

	// Turn-on delay of half-bridge 4 reads at 5:0
	property p_rd_hb4_turnon;
		@(posedge i_mclk) disable iff (i_rst)
		(i_rd_en && i_rd_addr == gtr_pkg::HB4_EFFECTIVE_ON_OFF_DELAY_OFS) |=>
			o_rd_data[5:0] == $past(words[1][5:0]);
	endproperty
	a_rd_hb4_turnon: assert property (p_rd_hb4_turnon) else $error("hb4 turn-on wrong");

	// Fall time of half-bridge 1 reads at 13:8
	property p_rd_hb1_fall;
		@(posedge i_mclk) disable iff (i_rst)
		(i_rd_en && i_rd_addr == gtr_pkg::HB1_RISE_FALL_TIME_OFS) |=>
			o_rd_data[13:8] == $past(words[2][13:8]);
	endproperty
	a_rd_hb1_fall: assert property (p_rd_hb1_fall) else $error("hb1 fall wrong");

	// Rise time of half-bridge 3 reads at 5:0
	property p_rd_hb3_rise;
		@(posedge i_mclk) disable iff (i_rst)
		(i_rd_en && i_rd_addr == gtr_pkg::HB3_RISE_FALL_TIME_OFS) |=>
			o_rd_data[5:0] == $past(words[4][5:0]);
	endproperty
	a_rd_hb3_rise: assert property (p_rd_hb3_rise) else $error("hb3 rise wrong");

	// Main scenarios
	c_read_delay: cover property (@(posedge i_mclk) disable iff (i_rst)
		i_rd_en && i_rd_addr == gtr_pkg::HB3_EFFECTIVE_ON_OFF_DELAY_OFS);
	c_read_risefall: cover property (@(posedge i_mclk) disable iff (i_rst)
		i_rd_en && i_rd_addr == gtr_pkg::HB2_RISE_FALL_TIME_OFS);
	c_restart_held: cover property (@(posedge i_mclk) disable iff (i_rst)
		i_restart && words[2] != gtr_pkg::REG_RESET);
	c_write_refused: cover property (@(posedge i_mclk) disable iff (i_rst) o_wr_refused);
endmodule

// >>> dv/gtr_host_model.sv
// Host model that reads and writes the bank over its register ports
module gtr_host_model (
	input wire logic i_mclk,
	input wire logic [15:0] i_rd_data,
	input wire logic i_rd_valid,
	input wire logic i_wr_refused,
	output logic o_rd_en,
	output gtr_pkg::gtr_addr_t o_rd_addr,
	output logic o_wr_en,
	output gtr_pkg::gtr_addr_t o_wr_addr
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus at time zero
	initial begin
		o_rd_en = 1'b0;
		o_rd_addr = 7'h00;
		o_wr_en = 1'b0;
		o_wr_addr = 7'h00;
	end

	// One read: request for one edge, answer taken one cycle later
	task automatic read(input gtr_pkg::gtr_addr_t addr, output logic vld, output logic [15:0] d);
		@(posedge i_mclk);
		o_rd_en <= 1'b1;
		o_rd_addr <= addr;
		@(posedge i_mclk);
		o_rd_en <= 1'b0;
		o_rd_addr <= ~addr;
		#1;
		vld = i_rd_valid;
		d = i_rd_data;
	endtask

	// One write: the refusal pulse is taken one cycle later
	task automatic write(input gtr_pkg::gtr_addr_t addr, output logic refused);
		@(posedge i_mclk);
		o_wr_en <= 1'b1;
		o_wr_addr <= addr;
		@(posedge i_mclk);
		o_wr_en <= 1'b0;
		o_wr_addr <= ~addr;
		#1;
		refused = i_wr_refused;
	endtask
endmodule

// >>> dv/testbench.sv
// Self-checking testbench of the gate timing readback bank
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk = 1'b0; // Bench clock
	logic rst = 1'b1; // Synchronous reset
	logic restart = 1'b0; // Restart event
	logic [4:0] lo_valid = 5'h00; // Low-field strobes
	logic [4:0] hi_valid = 5'h00; // High-field strobes
	logic [4:0][5:0] lo_cnt = '0; // Low-field counts
	logic [4:0][5:0] hi_cnt = '0; // High-field counts
	logic rd_en, wr_en, rd_valid, wr_refused;
	gtr_pkg::gtr_addr_t rd_addr, wr_addr;
	logic [15:0] rd_data;
	logic [15:0] exp_img [5]; // Expected register images
	int failures = 0;
	int checks_done = 0;

	// 100 MHz clock
	always #5 mclk = ~mclk;

	gtr_bank dut_u (.i_mclk(mclk), .i_rst(rst), .i_restart(restart), .i_rd_en(rd_en),
		.i_rd_addr(rd_addr), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_lo_valid(lo_valid),
		.i_lo_cnt(lo_cnt), .i_hi_valid(hi_valid), .i_hi_cnt(hi_cnt), .o_rd_data(rd_data),
		.o_rd_valid(rd_valid), .o_wr_refused(wr_refused));

	gtr_host_model host_u (.i_mclk(mclk), .i_rd_data(rd_data), .i_rd_valid(rd_valid),
		.i_wr_refused(wr_refused), .o_rd_en(rd_en), .o_rd_addr(rd_addr), .o_wr_en(wr_en),
		.o_wr_addr(wr_addr));

	// Compare one 16-bit result
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Read one address and compare data and valid pulse
	task automatic rd_chk(input gtr_pkg::gtr_addr_t addr, input logic [15:0] exp);
		logic v;
		logic [15:0] d;
		host_u.read(addr, v, d);
		check({15'h0000, v}, 16'h0001);
		check(d, exp);
	endtask

	// Present one new pair of counts to a slot for one edge
	task automatic feed(input int s, input logic [5:0] lo, input logic [5:0] hi);
		@(posedge mclk);
		lo_valid[s] <= 1'b1;
		lo_cnt[s] <= lo;
		hi_valid[s] <= 1'b1;
		hi_cnt[s] <= hi;
		@(posedge mclk);
		lo_valid <= 5'h00;
		hi_valid <= 5'h00;
	endtask

	// All registers and neighbouring unmapped places read zero
	task automatic t_zero();
		for (int s = 0; s < 5; s++) begin
			rd_chk(7'(7'h55 + s), 16'h0000);
		end
		rd_chk(7'h54, 16'h0000);
		rd_chk(7'h5A, 16'h0000);
		$display("test zero done");
	endtask

	// Each slot shows its latest counts in the right fields
	task automatic t_fields();
		logic [5:0] lo, hi;
		for (int s = 0; s < 5; s++) begin
			lo = 6'(6'h3F - s);
			hi = 6'(6'h20 + 3 * s);
			feed(s, 6'h15, 6'h2A);
			feed(s, lo, hi);
			exp_img[s] = {2'b00, hi, 2'b00, lo};
			rd_chk(7'(7'h55 + s), exp_img[s]);
		end
		$display("test fields done");
	endtask

	// Writes are refused on the bank and change nothing
	task automatic t_writes();
		logic r;
		for (int s = 0; s < 5; s++) begin
			host_u.write(7'(7'h55 + s), r);
			check({15'h0000, r}, 16'h0001);
			rd_chk(7'(7'h55 + s), exp_img[s]);
		end
		host_u.write(7'h60, r);
		check({15'h0000, r}, 16'h0000);
		$display("test writes done");
	endtask

	// Restart keeps both fields and zero reserved bits, also while it stands
	task automatic t_restart();
		@(posedge mclk);
		restart <= 1'b1;
		for (int s = 0; s < 5; s++) begin
			rd_chk(7'(7'h55 + s), exp_img[s]);
		end
		@(posedge mclk);
		restart <= 1'b0;
		$display("test restart done");
	endtask

	// Update one field and read it back at the very next edge
	task automatic upd_rd(input int s, input logic hi_sel, input logic [5:0] cnt);
		logic v;
		logic [15:0] d;
		@(posedge mclk);
		if (hi_sel) begin
			hi_valid[s] <= 1'b1;
			hi_cnt[s] <= cnt;
			exp_img[s][13:8] = cnt;
		end else begin
			lo_valid[s] <= 1'b1;
			lo_cnt[s] <= cnt;
			exp_img[s][5:0] = cnt;
		end
		fork
			begin
				@(posedge mclk);
				lo_valid <= 5'h00;
				hi_valid <= 5'h00;
			end
			host_u.read(7'(7'h55 + s), v, d);
		join
		check({15'h0000, v}, 16'h0001);
		check(d, exp_img[s]);
	endtask

	// A read right after a single-field update returns the new count
	task automatic t_quick();
		upd_rd(0, 1'b0, 6'h0C);
		upd_rd(4, 1'b1, 6'h33);
		upd_rd(1, 1'b1, 6'h07);
		upd_rd(2, 1'b0, 6'h21);
		$display("test quick update done");
	endtask

	// Reset in mid-run clears every register
	task automatic t_reset();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_zero();
		$display("test reset done");
	endtask

	// Print counts and the verdict, then stop
	task automatic print_verdict();
		$display("checks=%0d failures=%0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		t_zero();
		t_fields();
		t_writes();
		t_restart();
		t_quick();
		t_reset();
		print_verdict();
	end

	// Watchdog far beyond the roughly 110 cycles the tests need
	initial begin
		#100000;
		failures++;
		print_verdict();
	end
endmodule
